// File: core/cmbx_mailbox_ctrl.sv
// Purpose: transmit and receive control for the 32 mailboxes of one CAN channel
// Assumes: an external frame engine serialises frames and runs the acceptance filter
// Notes: the engine reports per-bit arbitration samples and frame outcomes
`timescale 1ns/100ps
module cmbx_mailbox_ctrl
   import cmbx_pkg::*;
(
   input wire logic clk,                          // 50 MHz block clock
   input wire logic reset_n,                      // asynchronous reset, active low
   input wire cmbx_opmode_type op_mode,           // operate, reset, halt or self-test
   input wire logic ctl_wr,                       // write strobe for a control word
   input wire logic [IDX_W-1:0] ctl_idx,          // mailbox addressed by write and read
   input wire cmbx_ctl_type ctl_wdata,            // new control word
   output cmbx_status_type ctl_rdata,             // registered status of ctl_idx
   output logic [NUM_MBOX-1:0] tx_done_flag,      // per-mailbox transmit done
   output logic [NUM_MBOX-1:0] tx_abort_done_flag, // per-mailbox abort done
   output logic [NUM_MBOX-1:0] abort_busy,        // abort waiting on the bus outcome
   output logic tx_complete_event,                // one-cycle pulse on a good send
   output logic bus_enable,                       // channel may take part on the bus
   output logic tx_start,                         // one-cycle pulse; tx_mbox takes the mailbox to send at the next edge
   output logic [IDX_W-1:0] tx_mbox,              // mailbox being sent
   output logic tx_active,                        // a frame of ours is on the bus
   output logic arb_lost,                         // one-cycle pulse on withdrawal
   input wire logic bit_strobe,                   // sample point of a bus bit
   input wire logic arb_field,                    // bit belongs to the arbitration field
   input wire logic own_bit,                      // bit we are sending
   input wire logic bus_bit,                      // bit seen on the bus
   input wire logic tx_ok,                        // frame ended without error
   input wire logic bus_err,                      // bus error during our frame
   input wire logic rx_valid,                     // engine offers a received frame
   output logic rx_ready,                         // frame taken this cycle
   input wire logic [ID_W-1:0] rx_id,             // identifier of the frame
   input wire logic rx_own,                       // frame was sent by this node
   input wire logic [NUM_MBOX-1:0] rx_match,      // filter match per mailbox
   output logic ack_drive,                        // one-cycle request to drive ACK
   output logic rx_out_valid,                     // placed frame waiting
   input wire logic rx_out_ready,                 // consumer takes the placed frame
   output cmbx_rx_entry_type rx_out_data          // mailbox number and identifier
);

   // ******************************************************************
   // reset release
   // ******************************************************************
   logic rst_meta, rst_n;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ******************************************************************
   // mailbox state and frame sequencing
   // ******************************************************************
   cmbx_mbox_type mb, next_mb;
   cmbx_txstate_type state, next_state;
   logic [IDX_W-1:0] cur, next_cur;
   logic next_tx_complete_event, next_ack_drive;
   cmbx_status_type next_ctl_rdata;
   logic [NUM_MBOX-1:0] pending, qual;
   logic lost_now, tx_fail, tx_success, abort_write, cur_is_target;
   logic rx_take, rx_accept, rx_push;
   logic [IDX_W-1:0] pend_idx, rx_idx;
   logic fifo_in_ready;

   function automatic logic [IDX_W-1:0] lowest(input logic [NUM_MBOX-1:0] v);
      logic [IDX_W-1:0] r;
      r = '0;
      for (int i = NUM_MBOX - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = IDX_W'(i);
         end
      end
      return r;
   endfunction

   assign bus_enable = (op_mode == OPM_OPERATE) || (op_mode == OPM_SELF_TEST);
   // code 11x is illegal, so a mailbox with both selects never sends
   assign pending = mb.tx_sel & ~mb.rx_sel & ~mb.tx_done & ~mb.abort_done
                    & ~mb.abort_req;
   assign pend_idx = lowest(pending);
   assign lost_now = (state == TX_ARB) && bit_strobe && arb_field
                     && own_bit && !bus_bit;
   assign tx_fail = (state != TX_IDLE) && (lost_now || bus_err);
   assign tx_success = (state == TX_DATA) && tx_ok && !bus_err;
   assign cur_is_target = (state != TX_IDLE) && (cur == ctl_idx);
   assign abort_write = ctl_wr && mb.tx_sel[ctl_idx] && !ctl_wdata.tx_mailbox_select
                        && !mb.tx_done[ctl_idx] && !mb.abort_done[ctl_idx];

   // a receive mailbox in single mode stops taking frames once it holds one
   assign qual = mb.rx_sel & ~mb.tx_sel & rx_match & ~(mb.single & mb.rx_full);
   assign rx_idx = lowest(qual);
   assign rx_ready = fifo_in_ready;
   assign rx_take = rx_valid && rx_ready;
   assign rx_accept = bus_enable && !(rx_own && (op_mode != OPM_SELF_TEST));
   assign rx_push = rx_take && rx_accept && (|qual);

   assign tx_done_flag = mb.tx_done;
   assign tx_abort_done_flag = mb.abort_done;
   assign abort_busy = mb.abort_req;
   assign tx_mbox = cur;
   assign tx_active = (state != TX_IDLE);
   assign arb_lost = lost_now;
   assign tx_start = (state == TX_IDLE) && bus_enable && (|pending);

   always_comb
   begin
      next_mb = mb;
      next_state = state;
      next_cur = cur;
      next_tx_complete_event = 1'b0;
      next_ack_drive = 1'b0;
      // software write first, so that a same-cycle hardware event wins
      if (ctl_wr)
      begin
         next_mb.tx_sel[ctl_idx] = ctl_wdata.tx_mailbox_select;
         next_mb.rx_sel[ctl_idx] = ctl_wdata.rx_mailbox_select;
         next_mb.single[ctl_idx] = ctl_wdata.single_attempt_enable;
         next_mb.tx_done[ctl_idx] = 1'b0;
         next_mb.abort_done[ctl_idx] = 1'b0;
         next_mb.rx_full[ctl_idx] = 1'b0;
         if (abort_write && cur_is_target)
         begin
            next_mb.abort_req[ctl_idx] = 1'b1;
         end
         else if (abort_write)
         begin
            next_mb.abort_done[ctl_idx] = 1'b1;
         end
      end
      case (state)
         TX_IDLE:
         begin
            if (tx_start)
            begin
               next_cur = pend_idx;
               next_state = TX_ARB;
            end
         end
         TX_ARB:
         begin
            if (tx_fail)
            begin
               next_state = TX_IDLE;
            end
            else if (!arb_field)
            begin
               next_state = TX_DATA;
            end
         end
         TX_DATA:
         begin
            if (tx_fail || tx_success)
            begin
               next_state = TX_IDLE;
            end
         end
         default:
         begin
            next_state = TX_IDLE;
         end
      endcase
      if (tx_success)
      begin
         next_mb.tx_done[cur] = 1'b1;
         next_mb.abort_req[cur] = 1'b0;
         next_mb.abort_done[cur] = 1'b0;
         next_tx_complete_event = 1'b1;
      end
      else if (tx_fail && (mb.single[cur] || mb.abort_req[cur] || abort_write && cur_is_target))
      begin
         // no transmit-complete event here; software must poll the flags
         next_mb.abort_done[cur] = 1'b1;
         next_mb.abort_req[cur] = 1'b0;
      end
      // a plain failure leaves the mailbox pending, so it is picked again
      if (rx_push)
      begin
         next_mb.rx_full[rx_idx] = 1'b1;
      end
      if (rx_take && rx_accept && rx_own && (|qual))
      begin
         next_ack_drive = 1'b1;
      end
      if (!bus_enable)
      begin
         // a frame in flight is dropped and retried on resumption
         next_state = TX_IDLE;
         next_tx_complete_event = 1'b0;
         // an abort waiting on a dropped frame ends here, else the box would never free
         if ((state != TX_IDLE) && next_mb.abort_req[cur])
         begin
            next_mb.abort_done[cur] = 1'b1;
            next_mb.abort_req[cur] = 1'b0;
         end
      end
      if (op_mode == OPM_RESET)
      begin
         next_mb = '{default: MBOX_RESET};
      end
      next_ctl_rdata.ctl.tx_mailbox_select = next_mb.tx_sel[ctl_idx];
      next_ctl_rdata.ctl.rx_mailbox_select = next_mb.rx_sel[ctl_idx];
      next_ctl_rdata.ctl.single_attempt_enable = next_mb.single[ctl_idx];
      next_ctl_rdata.tx_done_flag = next_mb.tx_done[ctl_idx];
      next_ctl_rdata.tx_abort_done_flag = next_mb.abort_done[ctl_idx];
      next_ctl_rdata.abort_busy = next_mb.abort_req[ctl_idx];
      next_ctl_rdata.rx_full = next_mb.rx_full[ctl_idx];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mb <= '{default: MBOX_RESET};
         state <= TX_IDLE;
         cur <= '0;
         tx_complete_event <= 1'b0;
         ack_drive <= 1'b0;
         ctl_rdata <= '0;
      end
      else
      begin
         mb <= next_mb;
         state <= next_state;
         cur <= next_cur;
         tx_complete_event <= next_tx_complete_event;
         ack_drive <= next_ack_drive;
         ctl_rdata <= next_ctl_rdata;
      end
   end

   // ******************************************************************
   // placed-frame buffer
   // ******************************************************************
   // a full buffer stalls the engine rather than dropping a placed frame
   cmbx_fifo #(.WIDTH(RX_ENTRY_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo
   (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_push),
      .in_ready(fifo_in_ready),
      .in_data({rx_idx, rx_id}),
      .out_valid(rx_out_valid),
      .out_ready(rx_out_ready),
      .out_data(rx_out_data)
   );

   // ******************************************************************
   // checks
   // ******************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [NUM_MBOX-1:0] below_mask;
   assign below_mask = (NUM_MBOX'(1) << rx_idx) - NUM_MBOX'(1);

   chk_rx_lowest_box: assert property (rx_push |-> qual[rx_idx] && !(|(qual & below_mask)))
      else $error("frame not placed in lowest qualifying mailbox");
   chk_own_frame_drop: assert property (rx_take && rx_own && op_mode == OPM_OPERATE
                                        |=> (mb.rx_full & ~$past(mb.rx_full)) == '0)
      else $error("own frame stored in operating mode");
   chk_self_test_ack: assert property (rx_take && rx_own && op_mode == OPM_SELF_TEST && (|qual)
                                       |=> ack_drive && mb.rx_full[$past(rx_idx)])
      else $error("self-test own frame not stored or acknowledged");
   chk_reset_wipe: assert property (op_mode == OPM_RESET |=> mb == '0 && !tx_active)
      else $error("reset mode left mailbox state");
   chk_halt_keeps_cfg: assert property (op_mode == OPM_HALT && !ctl_wr
                                        |=> $stable(mb.tx_sel) && $stable(mb.rx_sel)
                                            && !tx_active)
      else $error("halt mode changed configuration");
   chk_tx_done_set: assert property (tx_success && bus_enable |=> tx_done_flag[cur]
                                     && tx_complete_event && !tx_abort_done_flag[cur])
      else $error("good send did not set transmit done");
   chk_normal_retry: assert property (tx_fail && bus_enable && !mb.single[cur] && !mb.abort_req[cur]
                                      && !ctl_wr |=> pending[cur] && !tx_active)
      else $error("normal mailbox not kept pending after failure");
   chk_single_no_retry: assert property (tx_fail && bus_enable && mb.single[cur] && !ctl_wr
                                         |=> tx_abort_done_flag[cur] && !pending[cur]
                                             && !tx_complete_event)
      else $error("single attempt retried or not flagged");
   chk_abort_idle_box: assert property (abort_write && !cur_is_target && op_mode != OPM_RESET
                                        |=> tx_abort_done_flag[$past(ctl_idx)])
      else $error("abort before start not flagged");
   chk_abort_on_bus: assert property (abort_write && cur_is_target && bus_enable
                                      |=> abort_busy[cur] ##[0:1000] !abort_busy[cur]
                                          || !bus_enable)
      else $error("abort on bus never resolved");
   chk_arb_withdraw: assert property (lost_now |-> arb_lost ##1 state == TX_IDLE)
      else $error("lost arbitration but kept sending");
   chk_flags_hold: assert property (!ctl_wr && op_mode != OPM_RESET
                                    |=> (tx_done_flag & $past(tx_done_flag)) == $past(tx_done_flag)
                                        && (tx_abort_done_flag & $past(tx_abort_done_flag))
                                           == $past(tx_abort_done_flag))
      else $error("done flag dropped without a control write");

   cov_good_send: cover property (tx_start ##[1:50] tx_success);
   cov_lost_retry: cover property (lost_now ##[1:20] tx_start);
   cov_abort_on_bus: cover property (abort_write && cur_is_target ##[1:100] tx_fail);
   cov_fifo_full: cover property (rx_valid && !rx_ready);

endmodule

// File: shared/cmbx_pkg.sv
// Purpose: shared constants and carrier types for the CAN mailbox control block
// Assumes: one CAN channel, one 50 MHz clock, bus timing handled by the frame engine
// Notes: mode codes are packed as {tx select, rx select, single attempt}
//
// Summary of operation
// - a received frame lands in the lowest-numbered qualifying receive mailbox
// - in operating mode the block never stores a frame it sent itself
// - in self-test mode own frames are stored and acknowledged
// - reset mode wipes all mailbox configuration; bit rate changes only there
// - halt mode stops the bus but keeps every mailbox setting
// - the channel has 32 mailboxes, each usable for any mode
// - a successful transmission sets the mailbox transmit-done flag
// - a normal transmit mailbox retries after lost arbitration or bus error
// - a single-attempt transmit mailbox is tried once and never retried; a frame dropped when the bus is disabled is retried on resumption
// - single-attempt transmit failure sets the abort-done flag
// - a failed single attempt raises no transmit-complete event; software polls
// - an abort taking effect before transmission starts sets abort-done
// - an abort on a frame already on the bus completes on loss or error
// - a frame finishing despite a pending abort sets transmit-done, not abort-done
// - the block withdraws when its identifier loses bitwise arbitration
// - codes: 000 off, 010 rx, 011 single rx, 100 tx, 101 single tx; 11x illegal
package cmbx_pkg;

   localparam int NUM_MBOX = 32;
   localparam int IDX_W = 5;
   localparam int ID_W = 29;
   localparam int FIFO_DEPTH = 4;

   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_RX = 3'h2;
   localparam logic [2:0] MODE_RX_SINGLE = 3'h3;
   localparam logic [2:0] MODE_TX = 3'h4;
   localparam logic [2:0] MODE_TX_SINGLE = 3'h5;

   localparam logic [NUM_MBOX-1:0] MBOX_RESET = 32'h00000000;

   typedef enum logic [3:0]
   {
      OPM_OPERATE = 4'h1,
      OPM_RESET = 4'h2,
      OPM_HALT = 4'h4,
      OPM_SELF_TEST = 4'h8
   } cmbx_opmode_type;

   typedef enum logic [2:0]
   {
      TX_IDLE = 3'h1,
      TX_ARB = 3'h2,
      TX_DATA = 3'h4
   } cmbx_txstate_type;

   // control word written by software for one mailbox
   typedef struct packed
   {
      logic tx_mailbox_select;
      logic rx_mailbox_select;
      logic single_attempt_enable;
   } cmbx_ctl_type;

   // per-mailbox state, one bit of each vector per mailbox
   typedef struct packed
   {
      logic [NUM_MBOX-1:0] tx_sel;
      logic [NUM_MBOX-1:0] rx_sel;
      logic [NUM_MBOX-1:0] single;
      logic [NUM_MBOX-1:0] tx_done;
      logic [NUM_MBOX-1:0] abort_done;
      logic [NUM_MBOX-1:0] abort_req;
      logic [NUM_MBOX-1:0] rx_full;
   } cmbx_mbox_type;

   typedef struct packed
   {
      cmbx_ctl_type ctl;
      logic tx_done_flag;
      logic tx_abort_done_flag;
      logic abort_busy;
      logic rx_full;
   } cmbx_status_type;

   typedef struct packed
   {
      logic [IDX_W-1:0] mbox;
      logic [ID_W-1:0] id;
   } cmbx_rx_entry_type;

   localparam int RX_ENTRY_W = IDX_W + ID_W;

endpackage

// File: core/cmbx_fifo.sv
// Purpose: small valid/ready FIFO for placed receive frames
// Assumes: single clock, synchronised active-low reset copy, applied asynchronously
// Notes: full and empty come straight from the occupancy count
`timescale 1ns/100ps
module cmbx_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input wire logic clk,                  // block clock
   input wire logic rst_n,                // synchronised reset, active low
   input wire logic in_valid,             // writer offers a word
   output logic in_ready,                 // room for a word
   input wire logic [WIDTH-1:0] in_data,  // word to store
   output logic out_valid,                // a word is waiting
   input wire logic out_ready,            // reader takes the word
   output logic [WIDTH-1:0] out_data      // oldest word
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
   logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
   logic [CNT_W-1:0] count, next_count;
   logic push, pop;

   assign in_ready = (count != CNT_W'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb
   begin
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push)
      begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
         next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         next_count = count + 1'b1;
      end
      else if (pop && !push)
      begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= '0;
         end
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         mem <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

endmodule

// File: verification/cmbx_far_node.sv
// Purpose: frame engine and rival bus nodes facing the mailbox block
// Assumes: tasks are entered 1 ns after a rising clock edge
// Notes: released lines go recessive or show the inverse of their last value
`timescale 1ns/100ps
module cmbx_far_node
   import cmbx_pkg::*;
(
   input wire logic clk, // block clock
   input wire logic tx_active, // block frame on the bus
   input wire logic rx_ready, // block takes the frame
   output logic bit_strobe, // bit sample point
   output logic arb_field, // arbitration field bit
   output logic own_bit, // bit the block sends
   output logic bus_bit, // resolved bus level
   output logic tx_ok, // frame ended well
   output logic bus_err, // error on the bus
   output logic rx_valid, // frame offered
   output logic [ID_W-1:0] rx_id, // frame identifier
   output logic rx_own, // frame came from the block
   output logic [NUM_MBOX-1:0] rx_match // filter hits
);
   initial
   begin
      {bit_strobe, arb_field, tx_ok, bus_err, rx_valid, rx_own} = '0;
      {own_bit, bus_bit} = 2'h3;
      rx_id = '0;
      rx_match = '0;
   end
   // how: 0 good frame, 1 lost arbitration, 2 bus error
   task automatic run_tx(input int how, output logic went);
      went = 1'b0;
      for (int i = 0; i < 20 && !went; i++)
      begin
         went = tx_active;
         if (!went)
            @(posedge clk) #1;
      end
      if (went && how == 1)
      begin
         // a rival sends dominant where the block sends recessive
         {bit_strobe, arb_field, own_bit, bus_bit} = 4'hE;
         @(posedge clk) #1;
         {bit_strobe, arb_field, own_bit, bus_bit} = 4'h3;
      end
      else if (went)
      begin
         @(posedge clk) #1;
         tx_ok = (how == 0);
         bus_err = (how == 2);
         @(posedge clk) #1;
         {tx_ok, bus_err} = 2'h0;
      end
   endtask
   task automatic rx_frame(input logic [ID_W-1:0] id, input logic own,
      input logic [NUM_MBOX-1:0] hit);
      rx_valid = 1'b1;
      rx_id = id;
      rx_own = own;
      rx_match = hit;
      for (int i = 0; i < 20 && !rx_ready; i++)
         @(posedge clk) #1;
      @(posedge clk) #1;
      rx_valid = 1'b0;
      rx_id = ~id;
      rx_own = ~own;
      rx_match = ~hit;
      @(posedge clk) #1;
   endtask
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for the mailbox control block
// Assumes: 50 MHz clock, inputs driven 1 ns after each rising edge
// Notes: frame outcomes come from the far-node model
`timescale 1ns/100ps
module tb
   import cmbx_pkg::*;
;
   logic clk, reset_n, ctl_wr, rx_out_ready, went;
   cmbx_opmode_type op_mode;
   logic [IDX_W-1:0] ctl_idx, tx_mbox;
   cmbx_ctl_type ctl_wdata;
   cmbx_status_type ctl_rdata;
   logic [NUM_MBOX-1:0] tx_done_flag, tx_abort_done_flag, abort_busy, rx_match;
   logic tx_complete_event, bus_enable, tx_start, tx_active, arb_lost, ack_drive;
   logic bit_strobe, arb_field, own_bit, bus_bit, tx_ok, bus_err, rx_valid, rx_ready;
   logic rx_own, rx_out_valid;
   logic [ID_W-1:0] rx_id;
   cmbx_rx_entry_type rx_out_data;
   int error_cnt = 0, checks_done = 0, cyc = 0, ev_cnt = 0, lost_cnt = 0, ack_cnt = 0;
   cmbx_mailbox_ctrl dut (.clk, .reset_n, .op_mode, .ctl_wr, .ctl_idx, .ctl_wdata,
      .ctl_rdata, .tx_done_flag, .tx_abort_done_flag, .abort_busy, .tx_complete_event,
      .bus_enable, .tx_start, .tx_mbox, .tx_active, .arb_lost, .bit_strobe, .arb_field,
      .own_bit, .bus_bit, .tx_ok, .bus_err, .rx_valid, .rx_ready, .rx_id, .rx_own,
      .rx_match, .ack_drive, .rx_out_valid, .rx_out_ready, .rx_out_data);
   cmbx_far_node far (.clk, .tx_active, .rx_ready, .bit_strobe, .arb_field, .own_bit,
      .bus_bit, .tx_ok, .bus_err, .rx_valid, .rx_id, .rx_own, .rx_match);
   // ********************
   // clock, monitors, helpers
   // ********************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      ev_cnt += tx_complete_event;
      lost_cnt += arb_lost;
      ack_cnt += ack_drive;
      if (cyc >= 3000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk) #1;
   endtask
   task automatic wr(input int idx, input logic [2:0] mode);
      ctl_idx = idx[IDX_W-1:0];
      ctl_wdata = mode;
      ctl_wr = 1'b1;
      tick(1);
      ctl_wr = 1'b0;
      tick(1);
   endtask
   task automatic arm(input int idx, input logic [2:0] mode);
      wr(idx, MODE_OFF);
      check(abort_busy[idx], 1'b0);
      wr(idx, mode);
   endtask
   task automatic pop(input int mb, input logic [ID_W-1:0] id);
      for (int i = 0; i < 20 && !rx_out_valid; i++)
         tick(1);
      check(rx_out_data, {mb[IDX_W-1:0], id});
      rx_out_ready = 1'b1;
      tick(1);
      rx_out_ready = 1'b0;
      tick(1);
   endtask
   // ********************
   // scenarios
   // ********************
   task automatic t_tx;
      int e0;
      e0 = ev_cnt;
      arm(3, MODE_TX);
      far.run_tx(0, went);
      check(tx_mbox, 5'h03);
      tick(1);
      check({tx_done_flag[3], tx_abort_done_flag[3]}, 2'h2);
      check(ev_cnt - e0, 1);
      tick(5);
      check(tx_done_flag[3], 1'b1);
      wr(3, MODE_OFF);
      tick(1);
      check(tx_done_flag[3], 1'b0);
   endtask
   task automatic t_retry;
      int l0;
      l0 = lost_cnt;
      arm(5, MODE_TX);
      far.run_tx(1, went);
      check(lost_cnt - l0, 1);
      far.run_tx(2, went);
      check(went, 1'b1);
      far.run_tx(0, went);
      check(went, 1'b1);
      tick(1);
      check({tx_done_flag[5], tx_abort_done_flag[5]}, 2'h2);
   endtask
   task automatic t_single;
      int e0;
      for (int k = 0; k < 2; k++)
      begin
         e0 = ev_cnt;
         arm(6 + k, MODE_TX_SINGLE);
         far.run_tx(1 + k, went);
         tick(6);
         check(tx_active, 1'b0);
         check({tx_done_flag[6+k], tx_abort_done_flag[6+k]}, 2'h1);
         check(ev_cnt - e0, 0);
      end
   endtask
   task automatic t_abort;
      op_mode = OPM_HALT;
      arm(8, MODE_TX);
      arm(11, MODE_TX);
      tick(2);
      check({bus_enable, tx_active}, 2'h0);
      wr(8, MODE_OFF);
      tick(1);
      check(tx_abort_done_flag[8], 1'b1);
      op_mode = OPM_OPERATE;
      far.run_tx(0, went);
      check(tx_mbox, 5'h0B);
      tick(1);
      check(tx_done_flag[11], 1'b1);
      for (int k = 0; k < 2; k++)
      begin
         arm(9 + k, MODE_TX);
         for (int i = 0; i < 20 && !tx_active; i++)
            tick(1);
         wr(9 + k, MODE_OFF);
         check(abort_busy[9+k], 1'b1);
         far.run_tx(2 * (1 - k), went);
         tick(1);
         check({tx_done_flag[9+k], tx_abort_done_flag[9+k], abort_busy[9+k]},
            {k[0], ~k[0], 1'b0});
      end
   endtask
   task automatic t_rx;
      int a0;
      arm(2, MODE_RX);
      arm(4, MODE_RX);
      arm(1, MODE_RX_SINGLE);
      far.rx_frame(29'h0123, 1'b0, 32'h16);
      pop(1, 29'h0123);
      far.rx_frame(29'h0456, 1'b0, 32'h16);
      pop(2, 29'h0456);
      far.rx_frame(29'h0789, 1'b1, 32'h16);
      tick(2);
      check(rx_out_valid, 1'b0);
      op_mode = OPM_SELF_TEST;
      a0 = ack_cnt;
      far.rx_frame(29'h0ABC, 1'b1, 32'h10);
      pop(4, 29'h0ABC);
      check(ack_cnt - a0, 1);
      op_mode = OPM_OPERATE;
      // consumer stalls while four frames pile up
      for (int i = 0; i < 4; i++)
         far.rx_frame(29'h100 + 29'(i), 1'b0, 32'h04);
      tick(1);
      check(rx_ready, 1'b0);
      for (int i = 0; i < 4; i++)
         pop(2, 29'h100 + 29'(i));
      check(rx_ready, 1'b1);
   endtask
   task automatic t_mode_reset;
      op_mode = OPM_RESET;
      ctl_idx = 5'h02;
      tick(2);
      check({tx_done_flag, tx_abort_done_flag}, 64'h0);
      check({ctl_rdata.ctl, bus_enable}, 4'h0);
      op_mode = OPM_OPERATE;
      tick(2);
   endtask
   initial
   begin
      {reset_n, ctl_wr, rx_out_ready} = 3'h0;
      op_mode = OPM_OPERATE;
      ctl_idx = '0;
      ctl_wdata = MODE_OFF;
      repeat (5) @(posedge clk);
      #1;
      reset_n = 1'b1;
      tick(3);
      t_tx;
      t_retry;
      t_single;
      t_abort;
      t_rx;
      t_mode_reset;
      report_and_stop;
   end
endmodule
